// *** hdl/pwm_out_pkg.sv ***
// constants for the pwm output stage: register map, field positions, reset values, modes
package pwm_out_pkg;
  // -----------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // -----------------------------------------------------------
  localparam logic [1:0] IDX_SHUTDOWN = 2'h0;
  localparam logic [1:0] IDX_RESTART  = 2'h1;
  localparam logic [1:0] IDX_STEERING = 2'h2;
  // -----------------------------------------------------------
  // field positions
  // -----------------------------------------------------------
  localparam int FLAG_BIT    = 7;
  localparam int SRC_LSB     = 4;
  localparam int AC_LSB      = 2;
  localparam int BD_LSB      = 0;
  localparam int RESTART_BIT = 7;
  localparam int SYNC_BIT    = 4;
  // -----------------------------------------------------------
  // reset values
  // -----------------------------------------------------------
  localparam logic [7:0] SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] RESTART_RST  = 8'h00;
  localparam logic [7:0] STEERING_RST = 8'h01;
  localparam logic [2:0] PINS_RST     = 3'h1;
  // -----------------------------------------------------------
  // mode codes
  // -----------------------------------------------------------
  localparam logic [1:0] PWM_MODE_HI = 2'h3;
  localparam logic [1:0] CFG_SINGLE  = 2'h0;
  localparam logic [1:0] CFG_HALF    = 2'h2;
  localparam logic [1:0] SAFE_LOW    = 2'h0;
  localparam logic [1:0] SAFE_HIGH   = 2'h1;
  // one dead-band tick per enabled clk_in cycle (clock is the instruction cycle)
  localparam int DB_TICK_CLKS = 1;
  typedef enum logic [1:0] {ST_RUN, ST_SHUT, ST_WAIT} shut_state_t;
endpackage

// *** hdl/db_cfg_if.sv ***
// dead-band configuration carried from the register file to each delay unit
interface db_cfg_if;
  logic [6:0] count;
  logic       enable;
  modport src (output count, output enable);
  modport dst (input count, input enable);
endinterface

// *** hdl/pin_sync.sv ***
// three-flop synchroniser with agreement filter for asynchronous pins
module pin_sync #(
  parameter int               WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_out;

  // bits change only once the second and third stage agree
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_ff  <= INIT;
      s2_ff  <= INIT;
      s3_ff  <= INIT;
      out_ff <= INIT;
    end else if (clk_en_in) begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule

// *** hdl/dead_band.sv ***
// delays the inactive-to-active edge of one pwm output by a programmed tick count
module dead_band #(
  parameter int CW = 7
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  db_cfg_if.dst     cfg,
  input  wire logic pwm_active_in,
  output logic      pwm_active_out
);
  logic [CW-1:0] cnt_ff, nxt_cnt;

  // counter reloads while inactive, so a late rise never carries old state
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!pwm_active_in) begin
      nxt_cnt = cfg.count;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_ff <= '0;
    end else if (clk_en_in) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // falling edge passes at once; count longer than duty keeps it low all period
  assign pwm_active_out = pwm_active_in && (!cfg.enable || cnt_ff == '0);

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  a_db_fall_now: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !pwm_active_in |-> !pwm_active_out) else $error("dead band delayed a falling edge");
  a_db_rise_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(pwm_active_in) && $past(clk_en_in) && cfg.enable && cfg.count != '0 && $stable(cfg.count)
    |-> !pwm_active_out) else $error("dead band skipped the delay");
endmodule

// *** hdl/pwm_output_stage.sv ***
// pwm output stage: auto-shutdown, restart, dead band and pulse steering with avalon registers
// What this block does
// - shutdown_control bit 7 is the shutdown event flag; 1 means outputs are shut.
// - bits 6-4 pick shutdown sources: comparator one, two, fault low, combinations.
// - in shutdown pair A/C goes low, high or high impedance per bits 3-2.
// - in shutdown pair B/D goes low, high or high impedance per bits 1-0.
// - shutdown condition is a level; outputs stay shut while it lasts.
// - software writes to the flag are ignored while the condition persists.
// - after restart, pwm output resumes only at the next period start.
// - with auto restart, hardware clears the flag once the condition goes.
// - without auto restart, software must clear the flag to restart.
// - half-bridge dead band delays only inactive-to-active edges.
// - dead-band count gives the delay in instruction cycles.
// - steering works only with pwm mode 11 and output config 00.
// - each steering bit routes pwm to its pin, else port control.
// - steered pins take polarity from the low two mode bits.
// - shutdown states touch only pins given to pwm: steered pins, or A and B in half bridge.
// - steering changes at period start when sync bit set, else at once.
// - a shutdown event forces enabled pins to safe states without a clock.
// - software writing 1 to the flag forces a shutdown.
// - a dead band longer than the duty keeps that output inactive.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
module pwm_output_stage (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [1:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  input  wire logic        pwm_raw_in,
  input  wire logic        period_start_in,
  input  wire logic [3:0]  capture_pwm_mode_field_in,
  input  wire logic [1:0]  output_config_field_in,
  input  wire logic        fault_input_n_in,
  input  wire logic        comparator_one_out_in,
  input  wire logic        comparator_two_out_in,
  input  wire logic [3:0]  port_data_in,
  input  wire logic [3:0]  port_oe_n_in,
  output logic             pwm_out_a_out,
  output logic             pwm_out_a_oe_n_out,
  output logic             pwm_out_b_out,
  output logic             pwm_out_b_oe_n_out,
  output logic             pwm_out_c_out,
  output logic             pwm_out_c_oe_n_out,
  output logic             pwm_out_d_out,
  output logic             pwm_out_d_oe_n_out
);
  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  logic [2:0] pins_s;
  logic       cond_sync;
  logic       cond_async;
  logic [2:0] src_sel;

  pin_sync #(
    .WIDTH (3),
    .INIT  (pwm_out_pkg::PINS_RST)
  ) u_pin_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({comparator_two_out_in, comparator_one_out_in, fault_input_n_in}),
    .sync_out   (pins_s)
  );

  // -----------------------------------------------------------
  // register file and avalon slave
  // -----------------------------------------------------------
  logic [6:0]  shut_cfg_ff, nxt_shut_cfg;
  logic [7:0]  restart_ff, nxt_restart;
  logic [4:0]  steer_ff, nxt_steer;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        req;
  logic        wr_take;
  logic        sw_set;
  logic        sw_clr;
  logic        flag;

  assign req             = read_in || write_in;
  assign waitrequest_out = req && !ack_ff;
  assign readdata_out    = rdata_ff;
  assign wr_take         = write_in && ack_ff && byteenable_in[0];
  assign sw_set = wr_take && address_in == pwm_out_pkg::IDX_SHUTDOWN && writedata_in[pwm_out_pkg::FLAG_BIT];
  assign sw_clr = wr_take && address_in == pwm_out_pkg::IDX_SHUTDOWN && !writedata_in[pwm_out_pkg::FLAG_BIT];
  assign src_sel = shut_cfg_ff[pwm_out_pkg::SRC_LSB +: 3];

  always_comb begin
    nxt_ack      = req && !ack_ff;
    nxt_rdata    = rdata_ff;
    nxt_shut_cfg = shut_cfg_ff;
    nxt_restart  = restart_ff;
    nxt_steer    = steer_ff;
    if (req && !ack_ff) begin
      case (address_in)
        pwm_out_pkg::IDX_SHUTDOWN: nxt_rdata = {24'h0, flag, shut_cfg_ff};
        pwm_out_pkg::IDX_RESTART:  nxt_rdata = {24'h0, restart_ff};
        pwm_out_pkg::IDX_STEERING: nxt_rdata = {27'h0, steer_ff};
        default:                   nxt_rdata = 32'h0;
      endcase
    end
    if (wr_take) begin
      case (address_in)
        pwm_out_pkg::IDX_SHUTDOWN: nxt_shut_cfg = writedata_in[6:0];
        pwm_out_pkg::IDX_RESTART:  nxt_restart  = writedata_in[7:0];
        pwm_out_pkg::IDX_STEERING: nxt_steer    = writedata_in[4:0];
        default:                   nxt_steer    = steer_ff;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_ff      <= 1'b0;
      rdata_ff    <= 32'h0;
      shut_cfg_ff <= pwm_out_pkg::SHUTDOWN_RST[6:0];
      restart_ff  <= pwm_out_pkg::RESTART_RST;
      steer_ff    <= pwm_out_pkg::STEERING_RST[4:0];
    end else if (clk_en_in) begin
      ack_ff      <= nxt_ack;
      rdata_ff    <= nxt_rdata;
      shut_cfg_ff <= nxt_shut_cfg;
      restart_ff  <= nxt_restart;
      steer_ff    <= nxt_steer;
    end
  end

  // -----------------------------------------------------------
  // shutdown condition and state
  // -----------------------------------------------------------
  pwm_out_pkg::shut_state_t st_ff, nxt_st;
  logic shut_now;

  // same decode twice: raw pins force at once, filtered pins drive the flag
  always_comb begin
    cond_async = (src_sel[0] && comparator_one_out_in) || (src_sel[1] && comparator_two_out_in)
              || (src_sel[2] && !fault_input_n_in);
    cond_sync  = (src_sel[0] && pins_s[1]) || (src_sel[1] && pins_s[2]) || (src_sel[2] && !pins_s[0]);
  end

  // set beats clear; a clear during the condition is simply ignored
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      pwm_out_pkg::ST_RUN: begin
        if (cond_sync || sw_set) nxt_st = pwm_out_pkg::ST_SHUT;
      end
      pwm_out_pkg::ST_SHUT: begin
        if (cond_sync || sw_set) begin
          nxt_st = pwm_out_pkg::ST_SHUT;
        end else if (restart_ff[pwm_out_pkg::RESTART_BIT] || sw_clr) begin
          nxt_st = pwm_out_pkg::ST_WAIT;
        end
      end
      pwm_out_pkg::ST_WAIT: begin
        if (cond_sync || sw_set) begin
          nxt_st = pwm_out_pkg::ST_SHUT;
        end else if (period_start_in) begin
          nxt_st = pwm_out_pkg::ST_RUN;
        end
      end
      default: nxt_st = pwm_out_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= pwm_out_pkg::ST_RUN;
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  assign flag     = st_ff == pwm_out_pkg::ST_SHUT;
  assign shut_now = st_ff != pwm_out_pkg::ST_RUN || cond_async;

  // -----------------------------------------------------------
  // dead band and steering
  // -----------------------------------------------------------
  logic       pwm_mode, single_mode, half_mode;
  logic       db_a, db_b;
  logic [3:0] steer_act_ff, nxt_steer_act;

  assign pwm_mode    = capture_pwm_mode_field_in[3:2] == pwm_out_pkg::PWM_MODE_HI;
  assign single_mode = pwm_mode && output_config_field_in == pwm_out_pkg::CFG_SINGLE;
  assign half_mode   = pwm_mode && output_config_field_in == pwm_out_pkg::CFG_HALF;

  db_cfg_if u_db_cfg ();
  assign u_db_cfg.count  = restart_ff[6:0];
  assign u_db_cfg.enable = half_mode;

  dead_band #(.CW(7)) u_db_a (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .clk_en_in      (clk_en_in),
    .cfg            (u_db_cfg),
    .pwm_active_in  (pwm_raw_in),
    .pwm_active_out (db_a)
  );

  dead_band #(.CW(7)) u_db_b (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .clk_en_in      (clk_en_in),
    .cfg            (u_db_cfg),
    .pwm_active_in  (!pwm_raw_in),
    .pwm_active_out (db_b)
  );

  // synced steering waits for a period start so no pulse is ever cut
  always_comb begin
    nxt_steer_act = steer_act_ff;
    if (!steer_ff[pwm_out_pkg::SYNC_BIT] || period_start_in) begin
      nxt_steer_act = steer_ff[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      steer_act_ff <= pwm_out_pkg::STEERING_RST[3:0];
    end else if (clk_en_in) begin
      steer_act_ff <= nxt_steer_act;
    end
  end

  // -----------------------------------------------------------
  // pin ownership and levels
  // -----------------------------------------------------------
  logic [3:0] own_ff, nxt_own, val_ff, nxt_val;
  logic [3:0] pin_d, pin_oe_n;
  logic       pol_ac, pol_bd;

  assign pol_ac = capture_pwm_mode_field_in[1];
  assign pol_bd = capture_pwm_mode_field_in[0];

  // full-bridge modes leave the pins with the port; direction logic lives elsewhere
  always_comb begin
    nxt_own = 4'h0;
    nxt_val = 4'h0;
    if (single_mode) begin
      nxt_own = steer_act_ff;
      nxt_val = {pwm_raw_in ^ pol_bd, pwm_raw_in ^ pol_ac, pwm_raw_in ^ pol_bd, pwm_raw_in ^ pol_ac};
    end else if (half_mode) begin
      nxt_own = 4'h3;
      nxt_val = {2'h0, db_b ^ pol_bd, db_a ^ pol_ac};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      own_ff <= 4'h0;
      val_ff <= 4'h0;
    end else if (clk_en_in) begin
      own_ff <= nxt_own;
      val_ff <= nxt_val;
    end
  end

  // combinational on purpose: a fault must reach the pins without a clock edge
  always_comb begin
    logic [1:0] safe;
    safe = 2'h0;
    for (int i = 0; i < 4; i++) begin
      safe = (i % 2 == 0) ? shut_cfg_ff[pwm_out_pkg::AC_LSB +: 2] : shut_cfg_ff[pwm_out_pkg::BD_LSB +: 2];
      pin_d[i]    = port_data_in[i];
      pin_oe_n[i] = port_oe_n_in[i];
      if (own_ff[i] && shut_now) begin
        case (safe)
          pwm_out_pkg::SAFE_LOW: begin
            pin_d[i]    = 1'b0;
            pin_oe_n[i] = 1'b0;
          end
          pwm_out_pkg::SAFE_HIGH: begin
            pin_d[i]    = 1'b1;
            pin_oe_n[i] = 1'b0;
          end
          default: begin
            pin_d[i]    = 1'b0;
            pin_oe_n[i] = 1'b1;
          end
        endcase
      end else if (own_ff[i]) begin
        pin_d[i]    = val_ff[i];
        pin_oe_n[i] = 1'b0;
      end
    end
  end

  assign pwm_out_a_out      = pin_d[0];
  assign pwm_out_b_out      = pin_d[1];
  assign pwm_out_c_out      = pin_d[2];
  assign pwm_out_d_out      = pin_d[3];
  assign pwm_out_a_oe_n_out = pin_oe_n[0];
  assign pwm_out_b_oe_n_out = pin_oe_n[1];
  assign pwm_out_c_oe_n_out = pin_oe_n[2];
  assign pwm_out_d_oe_n_out = pin_oe_n[3];

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_flag_on_cond: assert property (cond_sync && clk_en_in |=> flag)
    else $error("flag not set by condition");
  a_source_off: assert property (src_sel == 3'h0 |-> !cond_sync && !cond_async)
    else $error("disabled source still shuts down");
  a_ac_pair_high: assert property (own_ff[0] && shut_now && shut_cfg_ff[3:2] == 2'h1
    |-> pwm_out_a_out && !pwm_out_a_oe_n_out) else $error("pair a/c not driven high");
  a_bd_pair_tri: assert property (own_ff[1] && shut_now && shut_cfg_ff[1] |-> pwm_out_b_oe_n_out)
    else $error("pair b/d not released");
  a_clear_ignored: assert property (sw_clr && cond_sync && clk_en_in |=> flag)
    else $error("flag cleared during condition");
  a_wait_period: assert property (st_ff == pwm_out_pkg::ST_WAIT && !period_start_in
    |=> st_ff != pwm_out_pkg::ST_RUN) else $error("pwm resumed before period start");
  a_auto_clear: assert property (flag && restart_ff[7] && !cond_sync && !sw_set && clk_en_in
    |=> !flag ##1 1'b1) else $error("auto restart did not clear flag");
  a_manual_hold: assert property (flag && !restart_ff[7] && !sw_clr && clk_en_in |=> flag)
    else $error("flag cleared without software");
  a_steer_hold: assert property (steer_ff[4] && !period_start_in && !write_in
    |=> $stable(steer_act_ff)) else $error("synced steering changed mid period");
  a_force_async: assert property (own_ff[0] && cond_async && shut_cfg_ff[3:2] == 2'h0
    |-> !pwm_out_a_out && !pwm_out_a_oe_n_out) else $error("fault did not force pin low");
  a_port_free: assert property (!own_ff[2] |-> pwm_out_c_oe_n_out == port_oe_n_in[2])
    else $error("port pin disturbed");

  c_auto_restart: cover property (flag && restart_ff[7] ##[1:20] st_ff == pwm_out_pkg::ST_RUN);
  c_sw_restart: cover property (sw_clr && flag ##[1:40] st_ff == pwm_out_pkg::ST_RUN);
  c_steer_sync: cover property (steer_ff[4] && period_start_in && steer_ff[3:0] != steer_act_ff);
  c_half_db: cover property (half_mode && restart_ff[6:0] != 7'h0 && $rose(pwm_out_a_out));
endmodule

// *** verification/bridge_switches.sv ***
// behavioural model of the power switch drivers hanging on the four output pins
module bridge_switches (
  input  wire logic        clk_in,
  input  wire logic        half_in,
  input  wire logic [3:0]  lvl_in,
  input  wire logic [3:0]  oe_n_in,
  output logic      [3:0]  wire_out,
  output logic      [15:0] shoot_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // released gate lines fall to the driver's pull-down, never the stale level
  assign wire_out = lvl_in & ~oe_n_in;
  initial shoot_out = 16'h0;
  // upper and lower switch of one leg both on: shoot-through
  always @(posedge clk_in) begin
    if (half_in && wire_out[0] && wire_out[1]) begin
      shoot_out <= shoot_out + 16'h1;
    end
  end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the pwm output stage
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, raw = 1'b0, pstart = 1'b0;
  logic        flt_n = 1'b1, c1 = 1'b0, c2 = 1'b0, ar, e;
  logic [1:0]  addr = 2'h0, cfg = 2'h0, safe_ac = 2'h0, safe_bd = 2'h0;
  logic [3:0]  be = 4'hf, mode = 4'hc, port_data = 4'h0, port_oe_n = 4'hf, steer = 4'h1;
  logic [31:0] wdata = 32'h0, q32, v;
  wire  [31:0] rdata;
  wire         wait_req;
  wire  [3:0]  pin_v, pin_oe_n, wire_lvl;
  wire  [15:0] shoot;
  int          err_total = 0, checked = 0, n, ta, tb, hi;
  integer      seed = 32'hbb277a1b;

  always #25 clk = ~clk;

  pwm_output_stage dut (.clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .address_in(addr),
    .read_in(rd), .write_in(wr), .byteenable_in(be), .writedata_in(wdata), .readdata_out(rdata),
    .waitrequest_out(wait_req), .pwm_raw_in(raw), .period_start_in(pstart),
    .capture_pwm_mode_field_in(mode), .output_config_field_in(cfg), .fault_input_n_in(flt_n),
    .comparator_one_out_in(c1), .comparator_two_out_in(c2), .port_data_in(port_data),
    .port_oe_n_in(port_oe_n), .pwm_out_a_out(pin_v[0]), .pwm_out_a_oe_n_out(pin_oe_n[0]),
    .pwm_out_b_out(pin_v[1]), .pwm_out_b_oe_n_out(pin_oe_n[1]), .pwm_out_c_out(pin_v[2]),
    .pwm_out_c_oe_n_out(pin_oe_n[2]), .pwm_out_d_out(pin_v[3]), .pwm_out_d_oe_n_out(pin_oe_n[3]));

  bridge_switches load (.clk_in(clk), .half_in(cfg == 2'h2), .lvl_in(pin_v), .oe_n_in(pin_oe_n),
    .wire_out(wire_lvl), .shoot_out(shoot));

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task final_report();
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // avalon master: hold the request until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 64);
    if (k >= 64) begin
      err_total++;
      final_report();
    end
    q32 = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task rd_chk(input logic [1:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q32, {24'h0, exp});
  endtask

  task pulse();
    @(posedge clk);
    pstart <= 1'b1;
    @(posedge clk);
    pstart <= 1'b0;
  endtask

  function automatic logic [3:0] owned();
    return (mode[3:2] == 2'b11 && cfg == 2'b00) ? steer : 4'h0;
  endfunction

  function automatic logic cond_of(logic [2:0] s);
    return (s[0] & c1) | (s[1] & c2) | (s[2] & ~flt_n);
  endfunction

  task check_pins(input logic shut);
    logic [3:0] own;
    logic [1:0] sf;
    logic       pol;
    own = owned();
    for (int i = 0; i < 4; i++) begin
      sf = i[0] ? safe_bd : safe_ac;
      pol = i[0] ? mode[0] : mode[1];
      if (!own[i]) begin
        chk(pin_oe_n[i], port_oe_n[i]);
        chk(pin_v[i], port_data[i]);
      end else if (shut && sf[1]) begin
        chk(pin_oe_n[i], 1'b1);
        chk(wire_lvl[i], 1'b0);
      end else begin
        chk(pin_oe_n[i], 1'b0);
        chk(pin_v[i], shut ? sf[0] : raw ^ pol);
      end
    end
  endtask

  task look(input logic shut);
    @(negedge clk);
    check_pins(shut);
    @(posedge clk);
  endtask

  task measure(input logic va, input logic vb);
    ta = -1;
    tb = -1;
    for (int k = 1; k < 200 && (ta < 0 || tb < 0); k++) begin
      @(negedge clk);
      if (ta < 0 && pin_v[0] === va) ta = k;
      if (tb < 0 && pin_v[1] === vb) tb = k;
    end
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  initial begin
    cyc(16);
    rst_n <= 1'b1;
    rd_chk(pwm_out_pkg::IDX_SHUTDOWN, 8'h00);
    rd_chk(pwm_out_pkg::IDX_RESTART, 8'h00);
    rd_chk(pwm_out_pkg::IDX_STEERING, 8'h01);
    bus(1'b1, 2'h3, 8'hff);
    rd_chk(2'h3, 8'h00);
    be <= 4'he;
    bus(1'b1, pwm_out_pkg::IDX_RESTART, 8'h7f);
    be <= 4'hf;
    rd_chk(pwm_out_pkg::IDX_RESTART, 8'h00);
    v = $random(seed);
    bus(1'b1, pwm_out_pkg::IDX_RESTART, {1'b0, v[6:0]});
    rd_chk(pwm_out_pkg::IDX_RESTART, {1'b0, v[6:0]});
    // steering with immediate update, mixed with modes that refuse it
    for (int i = 0; i < 10; i++) begin
      v = $random(seed);
      mode <= (i < 7) ? {2'b11, v[1:0]} : v[3:0];
      // half bridge owns pins through the dead band, so it has its own scenario below
      cfg <= (i < 7 || v[5:4] == 2'h2) ? 2'b00 : v[5:4];
      raw <= v[6];
      port_data <= v[11:8];
      port_oe_n <= v[15:12];
      steer = (i == 0) ? 4'hf : v[19:16];
      bus(1'b1, pwm_out_pkg::IDX_STEERING, {4'h0, steer});
      cyc(2);
      look(1'b0);
      raw <= ~raw;
      cyc(2);
      look(1'b0);
    end
    // synchronised steering waits for the period start
    v = $random(seed);
    mode <= {2'b11, v[5:4]};
    cfg <= 2'b00;
    bus(1'b1, pwm_out_pkg::IDX_STEERING, {4'h1, ~steer});
    cyc(3);
    look(1'b0);
    rd_chk(pwm_out_pkg::IDX_STEERING, {4'h1, ~steer});
    pulse();
    steer = ~steer;
    cyc(2);
    look(1'b0);
    // forced shutdown by software, restart only at period start
    safe_ac = v[3:2];
    safe_bd = v[1:0];
    bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, {4'h8, v[3:0]});
    rd_chk(pwm_out_pkg::IDX_SHUTDOWN, {4'h8, v[3:0]});
    look(1'b1);
    bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, {4'h0, v[3:0]});
    rd_chk(pwm_out_pkg::IDX_SHUTDOWN, {4'h0, v[3:0]});
    look(1'b1);
    pulse();
    cyc(2);
    look(1'b0);
    // every source code against every input combination
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 8; c++) begin
        v = $random(seed);
        ar = v[4];
        safe_ac = v[3:2];
        safe_bd = v[1:0];
        bus(1'b1, pwm_out_pkg::IDX_RESTART, {ar, 7'h05});
        bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, {1'b0, s[2:0], v[3:0]});
        @(posedge clk);
        flt_n <= ~c[2];
        c1 <= c[0];
        c2 <= c[1];
        #1;
        e = cond_of(s[2:0]);
        check_pins(e);
        cyc(8);
        rd_chk(pwm_out_pkg::IDX_SHUTDOWN, {e, s[2:0], v[3:0]});
        if (e) begin
          bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, {1'b0, s[2:0], v[3:0]});
          rd_chk(pwm_out_pkg::IDX_SHUTDOWN, {1'b1, s[2:0], v[3:0]});
        end
        flt_n <= 1'b1;
        c1 <= 1'b0;
        c2 <= 1'b0;
        cyc(8);
        if (e) begin
          rd_chk(pwm_out_pkg::IDX_SHUTDOWN, {~ar, s[2:0], v[3:0]});
          look(1'b1);
          if (!ar) bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, {1'b0, s[2:0], v[3:0]});
          pulse();
          cyc(2);
          look(1'b0);
        end
      end
    end
    // dead band in half bridge: only rising edges wait
    // park the pins low first so the mode switch itself cannot look like shoot-through
    mode <= 4'hc;
    raw <= 1'b0;
    port_oe_n <= 4'hf;
    bus(1'b1, pwm_out_pkg::IDX_SHUTDOWN, 8'h00);
    v = $random(seed);
    n = 2 + v[4:0];
    bus(1'b1, pwm_out_pkg::IDX_RESTART, n[7:0]);
    cfg <= pwm_out_pkg::CFG_HALF;
    cyc(n + 6);
    raw <= 1'b1;
    measure(1'b1, 1'b0);
    chk(ta - tb, n);
    cyc(n + 6);
    raw <= 1'b0;
    measure(1'b0, 1'b1);
    chk(tb - ta, n);
    cyc(n + 6);
    raw <= 1'b1;
    cyc(n / 2);
    raw <= 1'b0;
    hi = 0;
    repeat (n + 6) begin
      @(negedge clk);
      if (pin_v[0] !== 1'b0) hi++;
    end
    chk(hi, 0);
    chk(shoot, 16'h0);
    final_report();
  end
endmodule
